// *** design/coa_defines.vh ***
// Constants for the operand addressing and decode logic.
`ifndef COA_DEFINES_VH
`define COA_DEFINES_VH

// ****************************************************************
// Operand modes
// ****************************************************************
`define COA_MODE_NONE 4'h0
`define COA_MODE_DIRECT 4'h1
`define COA_MODE_IND_SHORT 4'h2
`define COA_MODE_IND_WIDE 4'h3
`define COA_MODE_REGISTER 4'h4
`define COA_MODE_IMPLICIT 4'h5
`define COA_MODE_IMMEDIATE 4'h6
`define COA_MODE_INDEXED 4'h7
`define COA_MODE_BIT 4'h8

// ****************************************************************
// Implicit targets
// ****************************************************************
`define COA_IMP_NONE 3'h0
`define COA_IMP_ACC 3'h1
`define COA_IMP_CARRY 3'h2
`define COA_IMP_WIDE_PTR 3'h3
`define COA_IMP_ACC_B 3'h4

// ****************************************************************
// Immediate source
// ****************************************************************
`define COA_IMMSRC_NONE 2'h0
`define COA_IMMSRC_ONE 2'h1
`define COA_IMMSRC_TWO 2'h2
`define COA_IMMSRC_WIDE 2'h3

// ****************************************************************
// Fields, bases and reset values
// ****************************************************************
`define COA_BANK_MSB 4
`define COA_BANK_LSB 3
`define COA_SFR_BASE 8'h80
`define COA_BIT_RAM_BASE 4'h2
`define COA_RESET_BYTE 8'h00
`define COA_RESET_WORD 16'h0000
`define COA_LATENCY_CYCLES 1

`endif

// *** design/coa_bit_map.v ***
// Maps a bit address of the 256-bit space onto its byte and bit index.
`include "coa_defines.vh"

module coa_bit_map (
  input wire [7:0] i_bit_addr,   // Bit address from the instruction
  output wire [7:0] o_byte_addr, // Byte holding the bit
  output wire [2:0] o_bit_index  // Position of the bit in that byte
);

  // Low half lives in RAM bytes 20h-2Fh; high half in Special_function_registers at multiples of 8.
  assign o_byte_addr = i_bit_addr[7] ? {i_bit_addr[7:3], 3'h0} :
    {`COA_BIT_RAM_BASE, i_bit_addr[6:3]};
  assign o_bit_index = i_bit_addr[2:0];

endmodule

// *** design/coa_operand_decoder.v ***
// Operand addressing decoder for the 8-bit core.
`include "coa_defines.vh"

module coa_operand_decoder (
  input wire i_clock,                       // Core clock
  input wire i_rstn,                        // Synchronous reset, active low
  input wire i_valid,                       // Instruction bytes present
  input wire [7:0] i_opcode,                // Opcode byte
  input wire [7:0] i_operand_one,           // First byte after opcode
  input wire [7:0] i_operand_two,           // Second byte after opcode
  input wire [7:0] i_accumulator,           // Accumulator value
  input wire [15:0] i_wide_pointer_register, // Wide data pointer
  input wire [15:0] i_program_counter,      // Address of next instruction
  input wire [7:0] i_status_word,           // Program status word
  input wire [7:0] i_bank_register_zero,    // Pointer register 0 of bank
  input wire [7:0] i_bank_register_one,     // Pointer register 1 of bank
  output wire o_valid,                      // Decode result present
  output wire [3:0] o_mode,                 // Operand mode code
  output wire [2:0] o_implicit,             // Implicit target code
  output wire [7:0] o_ram_addr,             // Internal RAM or SFR address
  output wire o_sfr_select,                 // Direct-mode address falls in SFR space
  output wire [7:0] o_second_addr,          // Second direct address
  output wire o_second_valid,               // Second address in use
  output wire [15:0] o_wide_addr,           // Wide or program address
  output wire o_prog_read,                  // Program memory read
  output wire o_xdata,                      // External data space access
  output wire [15:0] o_immediate,           // Immediate value
  output wire o_imm_valid,                  // Immediate value in use
  output wire [7:0] o_bit_byte_addr,        // Byte holding the bit
  output wire [2:0] o_bit_index             // Bit position in that byte
);

  // ****************************************************************
  // Decode functions
  // ****************************************************************
  function [3:0] coa_mode;
    input [7:0] op;
    reg [3:0] hi;
    begin
      hi = op[7:4];
      coa_mode = `COA_MODE_NONE;
      if (op[3]) begin
        coa_mode = `COA_MODE_REGISTER;
      end else begin
        case (op[2:0])
          3'h6, 3'h7: begin
            coa_mode = `COA_MODE_IND_SHORT;
          end
          3'h5: begin
            coa_mode = (hi == 4'hA) ? `COA_MODE_NONE : `COA_MODE_DIRECT;
          end
          3'h4: begin
            case (hi)
              4'h0, 4'h1, 4'h8, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF: begin
                coa_mode = `COA_MODE_IMPLICIT;
              end
              default: begin
                coa_mode = `COA_MODE_IMMEDIATE;
              end
            endcase
          end
          3'h3: begin
            case (hi)
              4'h4, 4'h5, 4'h6: coa_mode = `COA_MODE_DIRECT;
              4'h7, 4'h8, 4'h9: coa_mode = `COA_MODE_INDEXED;
              4'hE, 4'hF: coa_mode = `COA_MODE_IND_SHORT;
              default: coa_mode = `COA_MODE_IMPLICIT;
            endcase
          end
          3'h2: begin
            case (hi)
              4'h0, 4'h1, 4'h2, 4'h3: coa_mode = `COA_MODE_NONE;
              4'h4, 4'h5, 4'h6: coa_mode = `COA_MODE_DIRECT;
              4'hE, 4'hF: coa_mode = `COA_MODE_IND_SHORT;
              default: coa_mode = `COA_MODE_BIT;
            endcase
          end
          3'h0: begin
            case (hi)
              4'h1, 4'h2, 4'h3, 4'hA, 4'hB: coa_mode = `COA_MODE_BIT;
              4'h9: coa_mode = `COA_MODE_IMMEDIATE;
              4'hC, 4'hD: coa_mode = `COA_MODE_DIRECT;
              4'hE, 4'hF: coa_mode = `COA_MODE_IND_WIDE;
              default: coa_mode = `COA_MODE_NONE;
            endcase
          end
          default: begin
            coa_mode = `COA_MODE_NONE;
          end
        endcase
      end
    end
  endfunction

  function [2:0] coa_implicit;
    input [7:0] op;
    begin
      case (op)
        8'h04, 8'h14, 8'hC4, 8'hD4, 8'hE4, 8'hF4: coa_implicit = `COA_IMP_ACC;
        8'h03, 8'h13, 8'h23, 8'h33: coa_implicit = `COA_IMP_ACC;
        8'h84, 8'hA4: coa_implicit = `COA_IMP_ACC_B;
        8'hA3: coa_implicit = `COA_IMP_WIDE_PTR;
        8'hB3, 8'hC3, 8'hD3: coa_implicit = `COA_IMP_CARRY;
        default: coa_implicit = `COA_IMP_NONE;
      endcase
    end
  endfunction

  // Immediates also ride along with register, direct and indirect modes.
  function [1:0] coa_imm_src;
    input [7:0] op;
    begin
      coa_imm_src = `COA_IMMSRC_NONE;
      if (op == 8'h90) begin
        coa_imm_src = `COA_IMMSRC_WIDE;
      end else if (op == 8'h75 || op == 8'h43 || op == 8'h53 ||
                   op == 8'h63) begin
        coa_imm_src = `COA_IMMSRC_TWO;
      end else if (op[7:4] == 4'h7 && (op[3] || op[2:1] == 2'h3)) begin
        coa_imm_src = `COA_IMMSRC_ONE;
      end else if (coa_mode(op) == `COA_MODE_IMMEDIATE) begin
        coa_imm_src = `COA_IMMSRC_ONE;
      end
    end
  endfunction

  // ****************************************************************
  // Combinational resolution
  // ****************************************************************
  wire [3:0] mode_now = coa_mode(i_opcode);
  wire [1:0] imm_src = coa_imm_src(i_opcode);
  wire [1:0] bank = i_status_word[`COA_BANK_MSB:`COA_BANK_LSB];
  wire [7:0] bit_byte;
  wire [2:0] bit_idx;

  coa_bit_map u_bit_map (
    .i_bit_addr(i_operand_one),
    .o_byte_addr(bit_byte),
    .o_bit_index(bit_idx)
  );

  reg [7:0] ram_addr_next;
  reg [15:0] wide_addr_next;
  reg [15:0] imm_next;
  reg [7:0] second_next;
  reg second_valid_next;
  always @* begin
    ram_addr_next = `COA_RESET_BYTE;
    wide_addr_next = `COA_RESET_WORD;
    case (mode_now)
      `COA_MODE_DIRECT: begin
        ram_addr_next = i_operand_one;
      end
      `COA_MODE_REGISTER: begin
        ram_addr_next = {3'h0, bank, i_opcode[2:0]};
      end
      `COA_MODE_IND_SHORT: begin
        ram_addr_next = i_opcode[0] ? i_bank_register_one :
          i_bank_register_zero;
      end
      `COA_MODE_IND_WIDE: begin
        wide_addr_next = i_wide_pointer_register;
      end
      `COA_MODE_INDEXED: begin
        wide_addr_next = (i_opcode == 8'h83) ?
          i_program_counter + {8'h00, i_accumulator} :
          i_wide_pointer_register + {8'h00, i_accumulator};
      end
      `COA_MODE_BIT: begin
        ram_addr_next = bit_byte;
      end
      default: begin
        ram_addr_next = `COA_RESET_BYTE;
      end
    endcase
  end

  always @* begin
    case (imm_src)
      `COA_IMMSRC_ONE: imm_next = {8'h00, i_operand_one};
      `COA_IMMSRC_TWO: imm_next = {8'h00, i_operand_two};
      `COA_IMMSRC_WIDE: imm_next = {i_operand_one, i_operand_two};
      default: imm_next = `COA_RESET_WORD;
    endcase
  end

  // Move between two direct places carries the source first.
  always @* begin
    second_valid_next = 1'b1;
    second_next = i_operand_one;
    if (i_opcode == 8'h85) begin
      second_next = i_operand_two;
    end else if (!((i_opcode[7:4] == 4'h8 || i_opcode[7:4] == 4'hA) &&
                   (i_opcode[3] || i_opcode[2:1] == 2'h3))) begin
      second_valid_next = 1'b0;
      second_next = `COA_RESET_BYTE;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // One stage keeps every decode at a fixed single-cycle latency.
  reg valid_reg;
  reg [3:0] mode_reg;
  reg [2:0] implicit_reg;
  reg [7:0] ram_addr_reg;
  reg sfr_reg;
  reg [7:0] second_reg;
  reg second_valid_reg;
  reg [15:0] wide_addr_reg;
  reg prog_read_reg;
  reg xdata_reg;
  reg [15:0] imm_reg;
  reg imm_valid_reg;
  reg [7:0] bit_byte_reg;
  reg [2:0] bit_index_reg;

  always @(posedge i_clock) begin
    if (!i_rstn) begin
      valid_reg <= 1'b0;
      mode_reg <= `COA_MODE_NONE;
      implicit_reg <= `COA_IMP_NONE;
      ram_addr_reg <= `COA_RESET_BYTE;
      sfr_reg <= 1'b0;
      second_reg <= `COA_RESET_BYTE;
      second_valid_reg <= 1'b0;
      wide_addr_reg <= `COA_RESET_WORD;
      prog_read_reg <= 1'b0;
      xdata_reg <= 1'b0;
      imm_reg <= `COA_RESET_WORD;
      imm_valid_reg <= 1'b0;
      bit_byte_reg <= `COA_RESET_BYTE;
      bit_index_reg <= 3'h0;
    end else begin
      valid_reg <= i_valid;
      if (i_valid) begin
        mode_reg <= mode_now;
        implicit_reg <= coa_implicit(i_opcode);
        ram_addr_reg <= ram_addr_next;
        sfr_reg <= (mode_now == `COA_MODE_DIRECT) &&
          (i_operand_one >= `COA_SFR_BASE);
        second_reg <= second_next;
        second_valid_reg <= second_valid_next;
        wide_addr_reg <= wide_addr_next;
        prog_read_reg <= (i_opcode == 8'h83) || (i_opcode == 8'h93);
        xdata_reg <= (i_opcode[7:5] == 3'h7) && (i_opcode[3:2] == 2'h0) &&
          (i_opcode[1:0] != 2'h1);
        imm_reg <= imm_next;
        imm_valid_reg <= (imm_src != `COA_IMMSRC_NONE);
        bit_byte_reg <= (mode_now == `COA_MODE_BIT) ? bit_byte :
          `COA_RESET_BYTE;
        bit_index_reg <= (mode_now == `COA_MODE_BIT) ? bit_idx : 3'h0;
      end
    end
  end

  assign o_valid = valid_reg;
  assign o_mode = mode_reg;
  assign o_implicit = implicit_reg;
  assign o_ram_addr = ram_addr_reg;
  assign o_sfr_select = sfr_reg;
  assign o_second_addr = second_reg;
  assign o_second_valid = second_valid_reg;
  assign o_wide_addr = wide_addr_reg;
  assign o_prog_read = prog_read_reg;
  assign o_xdata = xdata_reg;
  assign o_immediate = imm_reg;
  assign o_imm_valid = imm_valid_reg;
  assign o_bit_byte_addr = bit_byte_reg;
  assign o_bit_index = bit_index_reg;

endmodule

// *** sim/coa_core_regs.sv ***
// Model of the bank pointer registers held in internal data RAM.
module coa_core_regs (
  input logic [7:0] i_status_word, // Bank select in bits 4:3
  output logic [7:0] o_bank_register_zero, // Pointer 0 of the bank
  output logic [7:0] o_bank_register_one // Pointer 1 of the bank
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each location holds its RAM address XOR A5h, so every bank and
  // register gives a distinct pointer and a wrong bank is seen at once.
  assign o_bank_register_zero =
    {3'h0, i_status_word[4:3], 3'h0} ^ 8'hA5;
  assign o_bank_register_one =
    {3'h0, i_status_word[4:3], 3'h1} ^ 8'hA5;
endmodule

// *** sim/coa_operand_decoder_assertions.sv ***
// Concurrent checks on the operand addressing decoder ports.
`include "coa_defines.vh"
module coa_dec_checker (
  input logic i_clock, // Core clock
  input logic i_rstn, // Reset, active low
  input logic i_valid, // Request
  input logic [7:0] i_opcode, // Opcode
  input logic [7:0] i_operand_one, // First operand byte
  input logic [7:0] i_accumulator, // Accumulator
  input logic [15:0] i_wide_pointer_register, // Wide pointer
  input logic [7:0] i_status_word, // Status word
  input logic [7:0] i_bank_register_zero, // Pointer 0
  input logic o_valid, // Result present
  input logic [3:0] o_mode, // Mode code
  input logic [2:0] o_implicit, // Implicit target
  input logic [7:0] o_ram_addr, // RAM address
  input logic o_sfr_select, // SFR space
  input logic [15:0] o_wide_addr, // Wide address
  input logic o_prog_read, // Program read
  input logic o_xdata, // External data
  input logic [15:0] o_immediate, // Immediate
  input logic o_imm_valid, // Immediate used
  input logic [2:0] o_bit_index // Bit position
);
  timeunit 1ns;
  timeprecision 1ns;
  wire [7:0] reg_addr_w = {3'h0, i_status_word[4:3], i_opcode[2:0]};
  wire [15:0] idx_w = i_wide_pointer_register + {8'h00, i_accumulator};
  wire [2:0] bidx_w = i_operand_one[2:0];
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  // ****************************************************************
  // Decode checks
  // ****************************************************************
  valid_latency_a: assert property (i_valid |=> o_valid)
    else $error("result flag missing one cycle after request");
  idle_hold_a: assert property (!i_valid |=>
    !o_valid && $stable(o_mode))
    else $error("result changed without a request");
  direct_addr_a: assert property (i_valid && i_opcode == 8'hE5 |=>
    o_ram_addr == $past(i_operand_one) && o_sfr_select == o_ram_addr[7])
    else $error("direct address or SFR select wrong");
  short_ptr_a: assert property (i_valid && i_opcode == 8'hE6 |=>
    o_mode == `COA_MODE_IND_SHORT &&
    o_ram_addr == $past(i_bank_register_zero))
    else $error("short pointer address wrong");
  wide_ptr_a: assert property (i_valid && i_opcode == 8'hE0 |=>
    o_wide_addr == $past(i_wide_pointer_register) && o_xdata)
    else $error("wide pointer address wrong");
  bank_reg_a: assert property (i_valid && i_opcode[7:3] == 5'h1D |=>
    o_mode == `COA_MODE_REGISTER && o_ram_addr == $past(reg_addr_w))
    else $error("bank register address wrong");
  imm_value_a: assert property (i_valid && i_opcode == 8'h74 |=>
    o_imm_valid && o_immediate == {8'h00, $past(i_operand_one)})
    else $error("immediate value wrong");
  imp_acc_a: assert property (i_valid && i_opcode == 8'hE4 |=>
    o_mode == `COA_MODE_IMPLICIT && o_implicit == `COA_IMP_ACC)
    else $error("implicit accumulator target wrong");
  indexed_a: assert property (i_valid && i_opcode == 8'h93 |=>
    o_prog_read && o_wide_addr == $past(idx_w))
    else $error("indexed program address wrong");
  bit_index_a: assert property (i_valid && i_opcode == 8'hD2 |=>
    o_mode == `COA_MODE_BIT && o_bit_index == $past(bidx_w))
    else $error("bit index wrong");
endmodule
bind coa_operand_decoder coa_dec_checker u_chk (
  .i_clock(i_clock),
  .i_rstn(i_rstn),
  .i_valid(i_valid),
  .i_opcode(i_opcode),
  .i_operand_one(i_operand_one),
  .i_accumulator(i_accumulator),
  .i_wide_pointer_register(i_wide_pointer_register),
  .i_status_word(i_status_word),
  .i_bank_register_zero(i_bank_register_zero),
  .o_valid(o_valid),
  .o_mode(o_mode),
  .o_implicit(o_implicit),
  .o_ram_addr(o_ram_addr),
  .o_sfr_select(o_sfr_select),
  .o_wide_addr(o_wide_addr),
  .o_prog_read(o_prog_read),
  .o_xdata(o_xdata),
  .o_immediate(o_immediate),
  .o_imm_valid(o_imm_valid),
  .o_bit_index(o_bit_index)
);

// *** sim/coa_operand_decoder_tb_top.sv ***
// Self-checking bench for the operand addressing decoder.
`include "coa_defines.vh"
module coa_operand_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic i_valid = 1'b0;
  logic [7:0] i_opcode = 8'h00;
  logic [7:0] i_operand_one = 8'h00;
  logic [7:0] i_operand_two = 8'h00;
  logic [7:0] i_accumulator = 8'h00;
  logic [15:0] i_wide_pointer_register = 16'h0000;
  logic [15:0] i_program_counter = 16'h0000;
  logic [7:0] i_status_word = 8'h00;
  wire [7:0] i_bank_register_zero, i_bank_register_one;
  wire o_valid, o_sfr_select, o_second_valid, o_prog_read, o_xdata;
  wire o_imm_valid;
  wire [3:0] o_mode;
  wire [2:0] o_implicit, o_bit_index;
  wire [7:0] o_ram_addr, o_second_addr, o_bit_byte_addr;
  wire [15:0] o_wide_addr, o_immediate;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [7:0] bv;

  coa_operand_decoder DUT (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_valid(i_valid),
    .i_opcode(i_opcode), .i_operand_one(i_operand_one),
    .i_operand_two(i_operand_two), .i_accumulator(i_accumulator),
    .i_wide_pointer_register(i_wide_pointer_register),
    .i_program_counter(i_program_counter),
    .i_status_word(i_status_word),
    .i_bank_register_zero(i_bank_register_zero),
    .i_bank_register_one(i_bank_register_one),
    .o_valid(o_valid), .o_mode(o_mode), .o_implicit(o_implicit),
    .o_ram_addr(o_ram_addr), .o_sfr_select(o_sfr_select),
    .o_second_addr(o_second_addr), .o_second_valid(o_second_valid),
    .o_wide_addr(o_wide_addr), .o_prog_read(o_prog_read),
    .o_xdata(o_xdata), .o_immediate(o_immediate),
    .o_imm_valid(o_imm_valid), .o_bit_byte_addr(o_bit_byte_addr),
    .o_bit_index(o_bit_index)
  );
  coa_core_regs u_regs (.i_status_word(i_status_word),
    .o_bank_register_zero(i_bank_register_zero),
    .o_bank_register_one(i_bank_register_one));

  always #25 i_clock = ~i_clock;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Wide enough for a flag joined to a 16-bit address.
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Called at a falling edge; back-to-back calls give requests every cycle.
  task automatic send(input logic [7:0] op, a, b);
    i_opcode = op;
    i_operand_one = a;
    i_operand_two = b;
    i_valid = 1'b1;
    @(negedge i_clock);
    check(o_valid, 1'b1);
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_direct();
    send(8'hE5, 8'h7F, 8'h00);
    check(o_mode, `COA_MODE_DIRECT);
    check({o_sfr_select, o_ram_addr}, 16'h007F);
    check(o_second_valid, 1'b0);
    send(8'hE5, 8'h80, 8'h00);
    check({o_sfr_select, o_ram_addr}, 16'h0180);
    send(8'h85, 8'h30, 8'hC1);
    check(o_ram_addr, 8'h30);
    check({o_second_valid, o_second_addr}, 16'h01C1);
    send(8'hAE, 8'h55, 8'h00);
    check({o_second_valid, o_second_addr}, 16'h0155);
  endtask

  // Stray status bits are set so a wide bank field would be caught.
  task automatic t_banks();
    for (int k = 0; k < 4; k++) begin
      i_status_word = {3'h5, k[1:0], 3'h7};
      send(8'hE7, 8'h00, 8'h00);
      check(o_mode, `COA_MODE_IND_SHORT);
      check(o_ram_addr, {3'h0, k[1:0], 3'h1} ^ 8'hA5);
      send(8'hE6, 8'h00, 8'h00);
      check(o_ram_addr, {3'h0, k[1:0], 3'h0} ^ 8'hA5);
      for (int n = 0; n < 8; n++) begin
        send({5'h1D, n[2:0]}, 8'h00, 8'h00);
        check(o_ram_addr, {3'h0, k[1:0], n[2:0]});
      end
    end
  endtask

  task automatic t_wide_idx();
    i_wide_pointer_register = 16'hFFF0;
    i_accumulator = 8'h20;
    i_program_counter = 16'h1000;
    send(8'hE0, 8'h00, 8'h00);
    check({o_xdata, o_mode}, {1'b1, `COA_MODE_IND_WIDE});
    check(o_wide_addr, 16'hFFF0);
    send(8'h93, 8'h00, 8'h00);
    check({o_prog_read, o_wide_addr}, 17'h10010);
    send(8'h83, 8'h00, 8'h00);
    check({o_prog_read, o_wide_addr}, 17'h11020);
    send(8'h73, 8'h00, 8'h00);
    check({o_prog_read, o_mode}, {1'b0, `COA_MODE_INDEXED});
  endtask

  task automatic t_imp_imm();
    send(8'hE4, 8'h00, 8'h00);
    check({o_mode, o_implicit}, {`COA_MODE_IMPLICIT, `COA_IMP_ACC});
    send(8'hA4, 8'h00, 8'h00);
    check(o_implicit, `COA_IMP_ACC_B);
    send(8'hA3, 8'h00, 8'h00);
    check(o_implicit, `COA_IMP_WIDE_PTR);
    send(8'hD3, 8'h00, 8'h00);
    check(o_implicit, `COA_IMP_CARRY);
    send(8'h74, 8'h5A, 8'h00);
    check(o_mode, `COA_MODE_IMMEDIATE);
    check({o_imm_valid, o_immediate}, 17'h1005A);
    send(8'h90, 8'h12, 8'h34);
    check(o_immediate, 16'h1234);
    send(8'h75, 8'h30, 8'hC7);
    check(o_immediate, 16'h00C7);
  endtask

  task automatic t_bits();
    for (int n = 0; n < 4; n++) begin
      bv = (n == 0) ? 8'h0B : (n == 1) ? 8'h7F : (n == 2) ? 8'h80 : 8'h8D;
      send(8'hD2, bv, 8'h00);
      check(o_mode, `COA_MODE_BIT);
      check(o_bit_byte_addr, bv[7] ? bv & 8'hF8 : 8'h20 + bv[6:3]);
      check(o_bit_index, bv[2:0]);
    end
  endtask

  task automatic t_undef_hold();
    send(8'hA5, 8'h00, 8'h00);
    check(o_mode, `COA_MODE_NONE);
    send(8'hE5, 8'h44, 8'h00);
    i_valid = 1'b0;
    @(negedge i_clock);
    check({o_valid, o_ram_addr}, 16'h0044);
  endtask

  // A reset in mid-run must clear held results before the next request.
  task automatic t_reset_mid();
    send(8'h90, 8'h12, 8'h34);
    i_valid = 1'b0;
    i_rstn = 1'b0;
    repeat (2) @(negedge i_clock);
    check({o_imm_valid, o_immediate}, 17'h00000);
    check({o_valid, o_mode}, 16'h0000);
    i_rstn = 1'b1;
    send(8'hE9, 8'h00, 8'h00);
    check(o_ram_addr, 8'h19);
  endtask

  initial begin
    repeat (8) @(negedge i_clock);
    check({o_valid, o_mode}, 16'h0000);
    i_rstn = 1'b1;
    t_direct();
    t_banks();
    t_wide_idx();
    t_imp_imm();
    t_bits();
    t_undef_hold();
    t_reset_mid();
    close_out();
  end
endmodule
